/* File: rtl/flash_host_pkg.sv */
// Constants shared by the parallel flash command host
package flash_host_pkg;
    // ****************************************
    // Register map (word index on the command port)
    // ****************************************
    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h1;
    localparam logic [3:0] REG_WDATA  = 4'h2;
    localparam logic [3:0] REG_CTRL   = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RDATA  = 4'h5;
    localparam int         CTRL_BYTE  = 0;
    localparam int         CTRL_SUSP  = 1;
    localparam int         CMD_OP_W   = 3;

    // ****************************************
    // Operations issued through the command register
    // ****************************************
    typedef enum logic [2:0] {
        OP_READ    = 3'h0,
        OP_WRITE   = 3'h1,
        OP_RESET   = 3'h2,
        OP_AUTOSEL = 3'h3,
        OP_QUERY   = 3'h4,
        OP_SEC_IN  = 3'h5,
        OP_SEC_OUT = 3'h6
    } op_t;

    // Host copy of the device mode
    typedef enum logic [2:0] {
        MODE_READ    = 3'h0,
        MODE_SUSP    = 3'h1,
        MODE_AUTOSEL = 3'h2,
        MODE_QUERY   = 3'h3,
        MODE_SECURE  = 3'h4
    } mode_t;

    // ****************************************
    // Command bus cycles
    // ****************************************
    localparam logic [23:0] UNLOCK1_ADDR = 24'h000555;
    localparam logic [23:0] UNLOCK2_ADDR = 24'h0002AA;
    localparam logic [23:0] QUERY_ADDR   = 24'h000055;
    localparam logic [23:0] ZERO_ADDR    = 24'h000000;
    localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
    localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [15:0] RESET_DATA   = 16'h00F0;
    localparam logic [15:0] AUTOSEL_DATA = 16'h0090;
    localparam logic [15:0] QUERY_DATA   = 16'h0098;
    localparam logic [15:0] SEC_IN_DATA  = 16'h0088;
    localparam logic [15:0] SEC_OUT_DATA = 16'h0000;
    localparam int          TIMEOUT_BIT  = 5;
    localparam int          ABORT_BIT    = 1;

    // ****************************************
    // Pin timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int T_SETUP_NS    = 10;
    localparam int T_WP_NS       = 40;
    localparam int T_ACC_NS      = 100;
    localparam int T_REC_NS      = 20;
    localparam int SYNC_STAGES   = 2;
    localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] WP_CYC    = 8'((T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] ACC_CYC   = 8'((T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + SYNC_STAGES);
    localparam logic [7:0] REC_CYC   = 8'((T_REC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
endpackage

/* File: rtl/flash_cmd_host.sv */
// Host controller issuing command sequences to a parallel NOR flash
//
// Overview of operation
// [R1] Device starts in read mode, no command
// [R2] Erase suspend gives reads of other sectors
// [R3] Timeout flag seen: host writes reset command
// [R4] Reset recognised by data, address ignored
// [R5] Reset aborts erase sequence before erasing
// [R6] Reset aborts program sequence, suspend kept
// [R7] Reset leaves autoselect, back to prior mode
// [R8] Buffer abort flag needs abort reset sequence
// [R9] Bad sequence: host writes reset to recover
// [R10] Address taken at last falling strobe edge
// [R11] Data taken at first rising strobe edge
// [R12] Two unlocks plus command enter autoselect
// [R13] Identifier addresses, doubled in byte width
// [R14] Lock indicator and sector protect addresses
// [R15] Autoselect only from read or suspend-read
// [R16] Three-cycle enter, four-cycle exit secure sector
// [R17] No bypass or acceleration in secure sector
// [R18] Query typical timeouts given as exponents
// [R19] Query maximum timeouts as typical multiples
// [R20] Query size and write buffer geometry
// [R21] Region one 128 blocks, others zero
// [R22] Extended query table at word 40h
// [R23] Query command from read or autoselect
// [R24] Reset returns to normal sector access
// [R25] Byte width query at doubled address
// [R26] Stray write leaves resettable state
`timescale 1ns/1ps
`default_nettype none

module flash_cmd_host (
    input  wire logic        clk_sys,    // System clock
    input  wire logic        srst,       // Synchronous reset, active high
    input  wire logic [3:0]  reg_addr,   // Register index
    input  wire logic [31:0] reg_wdata,  // Register write data
    input  wire logic        reg_wr,     // Write strobe
    input  wire logic        reg_rd,     // Read strobe
    output logic      [31:0] reg_rdata,  // Read data, cycle after strobe
    output logic             ce_n,       // Flash chip select
    output logic             we_n,       // Flash write strobe
    output logic             oe_n,       // Flash output strobe
    output logic      [23:0] flash_addr, // Flash address lines
    output logic      [15:0] dq_o,       // Flash data, driven value
    output logic             dq_oe_n,    // Flash data driver enable, low drives
    input  wire logic [15:0] dq_i        // Flash data, pin level
);
    // ****************************************
    // Sequence table
    // ****************************************
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_WPULS = 5'b00100,
        ST_RPULS = 5'b01000,
        ST_REC   = 5'b10000
    } state_t;

    // Returns {address, data, last} of one command cycle
    function automatic logic [40:0] seq_step(input logic [2:0] op, input logic [1:0] idx, input logic abort,
                                             input logic [23:0] a, input logic [15:0] d);
        logic [40:0] r;
        r = {a, d, 1'b1};
        if (idx == 2'h0 && !(op == flash_host_pkg::OP_RESET && !abort) && op != flash_host_pkg::OP_QUERY
            && op > flash_host_pkg::OP_WRITE) begin
            r = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::UNLOCK1_DATA, 1'b0};
        end else if (idx == 2'h1) begin
            r = {flash_host_pkg::UNLOCK2_ADDR, flash_host_pkg::UNLOCK2_DATA, 1'b0};
        end else begin
            unique case (op)
                // [R4] reset by data only
                flash_host_pkg::OP_RESET: begin
                    r = {abort ? flash_host_pkg::UNLOCK1_ADDR : flash_host_pkg::ZERO_ADDR,
                         flash_host_pkg::RESET_DATA, 1'b1};
                end
                flash_host_pkg::OP_AUTOSEL: begin
                    r = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::AUTOSEL_DATA, 1'b1};
                end
                flash_host_pkg::OP_QUERY: begin
                    r = {flash_host_pkg::QUERY_ADDR, flash_host_pkg::QUERY_DATA, 1'b1};
                end
                flash_host_pkg::OP_SEC_IN: begin
                    r = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::SEC_IN_DATA, 1'b1};
                end
                flash_host_pkg::OP_SEC_OUT: begin
                    if (idx == 2'h2) begin
                        r = {flash_host_pkg::UNLOCK1_ADDR, flash_host_pkg::AUTOSEL_DATA, 1'b0};
                    end else begin
                        r = {flash_host_pkg::ZERO_ADDR, flash_host_pkg::SEC_OUT_DATA, 1'b1};
                    end
                end
                default: r = {a, d, 1'b1};
            endcase
        end
        return r;
    endfunction

    // ****************************************
    // Registers and state
    // ****************************************
    logic [15:0] dq_s1_q, dq_s2_q;
    logic [23:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d, rdat_q, rdat_d;
    logic [1:0]  ctrl_q, ctrl_d;
    logic [2:0]  op_q, op_d;
    logic [1:0]  idx_q, idx_d;
    logic [7:0]  cnt_q, cnt_d;
    logic        busy_q, busy_d, refused_q, refused_d;
    logic        tmo_q, tmo_d, abt_q, abt_d;
    logic [2:0]  mode_q, mode_d;
    state_t      st_q, st_d;
    logic        ce_d, we_d, oe_d, dqoe_d;
    logic [23:0] fa_d;
    logic [15:0] dqo_d;
    logic [31:0] rd_d;
    logic [40:0] step;
    logic        ok;
    logic [2:0]  new_op;

    always_comb begin
        step   = seq_step(op_q, idx_q, abt_q, addr_q, wdata_q);
        new_op = reg_wdata[flash_host_pkg::CMD_OP_W-1:0];
        addr_d = addr_q;   wdata_d = wdata_q; ctrl_d = ctrl_q; rdat_d = rdat_q;
        op_d = op_q;       idx_d = idx_q;     cnt_d = cnt_q;   busy_d = busy_q;
        refused_d = refused_q; tmo_d = tmo_q; abt_d = abt_q;   mode_d = mode_q;
        st_d = st_q;       ce_d = ce_n;       we_d = we_n;     oe_d = oe_n;
        dqoe_d = dq_oe_n;  fa_d = flash_addr; dqo_d = dq_o;    rd_d = 32'h0000_0000;
        ok = 1'b1;
        // ****************************************
        // Command port
        // ****************************************
        if (reg_wr) begin
            unique case (reg_addr)
                flash_host_pkg::REG_ADDR:  addr_d = reg_wdata[23:0];
                flash_host_pkg::REG_WDATA: wdata_d = reg_wdata[15:0];
                flash_host_pkg::REG_CTRL:  ctrl_d = reg_wdata[1:0];
                flash_host_pkg::REG_CMD: begin
                    // [R15] autoselect only from read or suspend-read
                    if (new_op == flash_host_pkg::OP_AUTOSEL) begin
                        ok = mode_q == flash_host_pkg::MODE_READ || mode_q == flash_host_pkg::MODE_SUSP;
                    end
                    // [R23] query from read or autoselect
                    if (new_op == flash_host_pkg::OP_QUERY) begin
                        ok = mode_q == flash_host_pkg::MODE_READ || mode_q == flash_host_pkg::MODE_AUTOSEL;
                    end
                    // [R16] enter only from read, exit only from secure
                    if (new_op == flash_host_pkg::OP_SEC_IN) begin
                        ok = mode_q == flash_host_pkg::MODE_READ;
                    end
                    if (new_op == flash_host_pkg::OP_SEC_OUT) begin
                        ok = mode_q == flash_host_pkg::MODE_SECURE;
                    end
                    if (new_op > flash_host_pkg::OP_SEC_OUT) begin
                        ok = 1'b0;
                    end
                    if (busy_q || !ok) begin
                        refused_d = 1'b1;
                    end else begin
                        refused_d = 1'b0;
                        op_d = new_op; idx_d = 2'h0; busy_d = 1'b1;
                        st_d = ST_SETUP; cnt_d = flash_host_pkg::SETUP_CYC;
                    end
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                flash_host_pkg::REG_ADDR:   rd_d = {8'h00, addr_q};
                flash_host_pkg::REG_WDATA:  rd_d = {16'h0000, wdata_q};
                flash_host_pkg::REG_CTRL:   rd_d = {30'h0, ctrl_q};
                flash_host_pkg::REG_STATUS: rd_d = {24'h0, mode_q, abt_q, tmo_q, refused_q, 1'b0, busy_q};
                flash_host_pkg::REG_RDATA:  rd_d = {16'h0000, rdat_q};
                default: rd_d = 32'h0000_0000;
            endcase
        end
        // ****************************************
        // Pin sequencer
        // ****************************************
        unique case (st_q)
            ST_IDLE: ;
            ST_SETUP: begin
                // [R13] [R25] byte width doubles the address
                fa_d = ctrl_q[flash_host_pkg::CTRL_BYTE] ? {step[39:17], 1'b0} : step[40:17];
                dqo_d = step[16:1];
                dqoe_d = (op_q != flash_host_pkg::OP_READ) ? 1'b0 : 1'b1;
                if (cnt_q > 8'h01) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (op_q == flash_host_pkg::OP_READ) begin
                    ce_d = 1'b0; oe_d = 1'b0;
                    st_d = ST_RPULS; cnt_d = flash_host_pkg::ACC_CYC;
                end else begin
                    // [R10] address settled before both strobes fall
                    ce_d = 1'b0; we_d = 1'b0;
                    st_d = ST_WPULS; cnt_d = flash_host_pkg::WP_CYC;
                end
            end
            ST_WPULS: begin
                if (cnt_q > 8'h01) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    // [R11] data held until strobes rise
                    ce_d = 1'b1; we_d = 1'b1;
                    st_d = ST_REC; cnt_d = flash_host_pkg::REC_CYC;
                end
            end
            ST_RPULS: begin
                if (cnt_q > 8'h01) begin
                    cnt_d = cnt_q - 8'h01;
                end else begin
                    ce_d = 1'b1; oe_d = 1'b1;
                    rdat_d = dq_s2_q;
                    // [R3] [R8] catch error flags for the next reset
                    if (mode_q == flash_host_pkg::MODE_READ || mode_q == flash_host_pkg::MODE_SUSP) begin
                        tmo_d = tmo_q | dq_s2_q[flash_host_pkg::TIMEOUT_BIT];
                        abt_d = abt_q | dq_s2_q[flash_host_pkg::ABORT_BIT];
                    end
                    st_d = ST_REC; cnt_d = flash_host_pkg::REC_CYC;
                end
            end
            ST_REC: begin
                dqoe_d = 1'b1;
                if (cnt_q > 8'h01) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (op_q != flash_host_pkg::OP_READ && !step[0]) begin
                    idx_d = idx_q + 2'h1;
                    st_d = ST_SETUP; cnt_d = flash_host_pkg::SETUP_CYC;
                end else begin
                    st_d = ST_IDLE; busy_d = 1'b0;
                    unique case (op_q)
                        // [R7] [R9] [R26] reset restores read or suspend-read
                        flash_host_pkg::OP_RESET: begin
                            mode_d = ctrl_q[flash_host_pkg::CTRL_SUSP] ? flash_host_pkg::MODE_SUSP
                                                                       : flash_host_pkg::MODE_READ;
                            tmo_d = 1'b0; abt_d = 1'b0;
                        end
                        // [R12] autoselect stays until reset or query
                        flash_host_pkg::OP_AUTOSEL: mode_d = flash_host_pkg::MODE_AUTOSEL;
                        flash_host_pkg::OP_QUERY:   mode_d = flash_host_pkg::MODE_QUERY;
                        flash_host_pkg::OP_SEC_IN:  mode_d = flash_host_pkg::MODE_SECURE;
                        flash_host_pkg::OP_SEC_OUT: mode_d = flash_host_pkg::MODE_READ;
                        default: ;
                    endcase
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // ****************************************
    // State registers
    // ****************************************
    always_ff @(posedge clk_sys) begin
        dq_s1_q <= dq_i;
        dq_s2_q <= dq_s1_q;
        if (srst) begin
            // [R1] [R24] after reset assume read mode, normal sector
            addr_q <= 24'h000000; wdata_q <= 16'h0000; ctrl_q <= 2'h0; rdat_q <= 16'h0000;
            op_q <= flash_host_pkg::OP_READ; idx_q <= 2'h0; cnt_q <= 8'h00;
            busy_q <= 1'b0; refused_q <= 1'b0; tmo_q <= 1'b0; abt_q <= 1'b0;
            mode_q <= flash_host_pkg::MODE_READ; st_q <= ST_IDLE;
            ce_n <= 1'b1; we_n <= 1'b1; oe_n <= 1'b1; dq_oe_n <= 1'b1;
            flash_addr <= 24'h000000; dq_o <= 16'h0000; reg_rdata <= 32'h0000_0000;
        end else begin
            addr_q <= addr_d; wdata_q <= wdata_d; ctrl_q <= ctrl_d; rdat_q <= rdat_d;
            op_q <= op_d; idx_q <= idx_d; cnt_q <= cnt_d;
            busy_q <= busy_d; refused_q <= refused_d; tmo_q <= tmo_d; abt_q <= abt_d;
            mode_q <= mode_d; st_q <= st_d;
            ce_n <= ce_d; we_n <= we_d; oe_n <= oe_d; dq_oe_n <= dqoe_d;
            flash_addr <= fa_d; dq_o <= dqo_d; reg_rdata <= rd_d;
        end
    end
endmodule

`default_nettype wire

/* File: tb/flash_host_properties.sv */
// Pin-level checks for the flash command host
`timescale 1ns/1ps
`default_nettype none
module flash_host_properties (
    input wire logic        clk_sys,    // Clock
    input wire logic        srst,       // Sync reset
    input wire logic [3:0]  reg_addr,   // Index
    input wire logic [31:0] reg_wdata,  // Write data
    input wire logic        reg_wr,     // Write strobe
    input wire logic        reg_rd,     // Read strobe
    input wire logic [31:0] reg_rdata,  // Read data
    input wire logic        ce_n,       // Chip select
    input wire logic        we_n,       // Write strobe
    input wire logic        oe_n,       // Output strobe
    input wire logic [23:0] flash_addr, // Address
    input wire logic [15:0] dq_o,       // Data driven
    input wire logic        dq_oe_n,    // Drive enable
    input wire logic [15:0] dq_i        // Pin level
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    idle_after_reset_a: assert property (disable iff (1'b0) $fell(srst) |-> ce_n && we_n && oe_n && dq_oe_n)
        else $error("strobes active after reset");
    write_pulse_a: assert property ($fell(we_n) |-> !ce_n ##9 !we_n && !ce_n ##1 we_n && ce_n)
        else $error("write pulse not ten cycles");
    read_pulse_a: assert property ($fell(oe_n) |-> !ce_n ##26 !oe_n ##1 oe_n)
        else $error("read strobe not 27 cycles");
    no_write_read_a: assert property (!oe_n |-> we_n && dq_oe_n)
        else $error("read overlaps write or drive");
    drive_in_write_a: assert property (!we_n |-> !dq_oe_n)
        else $error("data not driven in write pulse");
    addr_hold_a: assert property (!ce_n && !$past(ce_n) |-> $stable(flash_addr))
        else $error("address moved under chip select");
    data_hold_a: assert property (!we_n && !$past(we_n) |-> $stable(dq_o))
        else $error("data moved under write strobe");
    recovery_gap_a: assert property ($rose(ce_n) |-> ce_n [*5])
        else $error("recovery shorter than five cycles");
    setup_first_a: assert property ($fell(ce_n) |-> $stable(flash_addr) && $stable(dq_o))
        else $error("strobe fell with address changing");
endmodule
`default_nettype wire

/* File: tb/flash_device_model.sv */
// Behavioural parallel NOR flash: modes, identifier and query tables
`timescale 1ns/1ps
`default_nettype none
module flash_device_model #(
    parameter logic [15:0] MFR_CODE = 16'h0001, // Arbitrary identity value
    parameter logic [15:0] DEV_CODE = 16'h0100, // Arbitrary identity value
    parameter logic [15:0] SERIAL   = 16'h0200, // Serial number base
    parameter int          ACC_NS   = 20        // Access delay
) (
    input  wire logic        byte_mode, // Byte width strap
    input  wire logic        ce_n,      // Chip select
    input  wire logic        we_n,      // Write strobe
    input  wire logic        oe_n,      // Output strobe
    input  wire logic [23:0] addr,      // Address lines
    input  wire logic [15:0] dq_o,      // Host data
    input  wire logic        dq_oe_n,   // Host drives when low
    output logic      [15:0] dq_i       // Resolved pin level
);
    logic [2:0]  mode = 3'h0;
    logic [1:0]  unl = 2'h0;
    logic        leave = 1'b0;
    logic        open_w = 1'b0;
    logic [23:0] a_lat, wa;
    logic [15:0] rv;
    task automatic take(input logic [11:0] a, input logic [15:0] d);
        if (d[7:0] == 8'hF0 && mode != 3'h4) begin
            mode = 3'h0;
            unl = 2'h0;
        end else if (leave) begin
            mode = (d == 16'h0) ? 3'h0 : mode;
            leave = 1'b0;
        // query from read or identifier mode
        end else if (d == 16'h0098 && a == 12'h055 && mode < 3'h3) begin
            mode = 3'h3;
        end else if (unl == 2'h0 && a == 12'h555 && d == 16'h00AA) begin
            unl = 2'h1;
        end else if (unl == 2'h1 && a == 12'h2AA && d == 16'h0055) begin
            unl = 2'h2;
        end else begin
            // third cycle picks the mode, nothing else offered
            if (unl == 2'h2 && a == 12'h555) begin
                case ({mode, d[7:0]})
                    {3'h4, 8'h90}: leave = 1'b1;
                    {3'h0, 8'h90}: mode = 3'h2;
                    {3'h0, 8'h88}: mode = 3'h4;
                    default: ;
                endcase
            end
            unl = 2'h0;
        end
    endtask
    // address on the later falling strobe
    always @(negedge we_n or negedge ce_n) begin
        if (!we_n && !ce_n && oe_n) begin
            a_lat = byte_mode ? addr >> 1 : addr;
            open_w = 1'b1;
        end
    end
    // data on the first rising strobe
    always @(posedge we_n or posedge ce_n) begin
        if (open_w) begin
            open_w = 1'b0;
            take(a_lat[11:0], dq_o);
        end
    end
    always_comb begin
        wa = byte_mode ? addr >> 1 : addr;
        rv = wa[15:0] ^ 16'h5A5A;
        // identifier codes, lock and protect status
        if (mode == 3'h2) begin
            case (wa[7:0])
                8'h00: rv = MFR_CODE;
                8'h01, 8'h0E, 8'h0F: rv = DEV_CODE + 16'(wa[3:0]);
                8'h02: rv = 16'h0001;
                8'h03: rv = 16'h0080;
                default: rv = 16'h0000;
            endcase
        end else if (mode == 3'h3) begin
            case (wa[7:0])
                8'h1F, 8'h20: rv = 16'h0007;
                8'h21: rv = 16'h000A;
                8'h23, 8'h2C, 8'h30, 8'h4C: rv = 16'h0001;
                8'h24, 8'h2A: rv = 16'h0005;
                8'h25: rv = 16'h0004;
                8'h27: rv = 16'h0017;
                8'h2D: rv = 16'h007F;
                8'h40: rv = 16'h0050;
                8'h46: rv = 16'h0002;
                default: rv = 16'h0000;
            endcase
        // secure region holds the serial number
        end else if (mode == 3'h4) begin
            rv = (wa < 24'h8) ? SERIAL + 16'(wa[2:0]) : 16'hFFFF;
        end
        if (byte_mode) begin
            rv[15:8] = 8'h00;
        end
    end
    // Released pins show the inverse so a stale value never passes
    assign #(ACC_NS) dq_i = !dq_oe_n ? dq_o : (!ce_n && !oe_n) ? rv : ~rv;
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the flash command host
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [15:0] MFR = 16'h00C3; // Arbitrary identity value
    localparam logic [15:0] DEV = 16'h2210; // Arbitrary identity value
    localparam logic [15:0] SER = 16'h3C00; // Arbitrary serial base
    typedef struct {string nm; logic [31:0] m; logic [31:0] e;} note_t;
    logic        clk_sys = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0, byte_mode = 1'b0;
    logic        ce_n, we_n, oe_n, dq_oe_n, to_e = 1'b0, ab_e = 1'b0;
    logic [2:0]  md_e = 3'h0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, lfsr = 32'hA8FA;
    logic [23:0] flash_addr;
    logic [15:0] dq_o, dq_i;
    logic [7:0]  qa [18] = '{8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h2A, 8'h2C, 8'h2D,
                             8'h2E, 8'h30, 8'h34, 8'h40, 8'h46, 8'h4C};
    logic [15:0] qv [18] = '{16'h7, 16'h7, 16'hA, 16'h0, 16'h1, 16'h5, 16'h4, 16'h0, 16'h17, 16'h5, 16'h1, 16'h7F,
                             16'h0, 16'h1, 16'h0, 16'h50, 16'h2, 16'h1};
    logic [23:0] ia [6] = '{24'h0, 24'h1, 24'hE, 24'hF, 24'h3, 24'h902};
    logic [15:0] iv [6] = '{MFR, DEV + 16'h1, DEV + 16'hE, DEV + 16'hF, 16'h0080, 16'h0001};
    int          errors = 0, checks = 0;
    note_t       q [$];
    always #2 clk_sys = ~clk_sys;
    flash_cmd_host dut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .flash_addr(flash_addr),
        .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i));
    flash_device_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .SERIAL(SER)) flash (.byte_mode(byte_mode), .ce_n(ce_n),
        .we_n(we_n), .oe_n(oe_n), .addr(flash_addr), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i));
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        @(posedge clk_sys);
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input string nm, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk_sys);
        q.push_back('{nm, m, e});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
    // Polls carry no note
    task automatic go(input logic [2:0] o);
        wr(flash_host_pkg::REG_CMD, {29'h0, o});
        for (int n = 0; n < 200; n++) begin
            @(posedge clk_sys);
            reg_addr <= flash_host_pkg::REG_STATUS;
            reg_rd <= 1'b1;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            @(negedge clk_sys);
            if (reg_rdata[0] === 1'b0)
                return;
        end
        errors++;
        summarize();
    endtask
    task automatic st(input logic rf);
        rd(flash_host_pkg::REG_STATUS, "status", 32'hFFFFFFFD, {24'h0, md_e, ab_e, to_e, rf, 2'b00});
    endtask
    task automatic op(input logic [2:0] o, input logic [2:0] md, input logic rf);
        go(o);
        md_e = md;
        if (o == 3'h2) begin
            to_e = 1'b0;
            ab_e = 1'b0;
        end
        st(rf);
    endtask
    task automatic rda(input logic [23:0] a, input logic [15:0] e);
        wr(flash_host_pkg::REG_ADDR, {8'h0, a});
        go(3'h0);
        if (md_e < 3'h2) begin
            to_e = to_e | e[5];
            ab_e = ab_e | e[1];
        end
        rd(flash_host_pkg::REG_RDATA, "flash data", 32'hFFFFFFFF, {16'h0, e});
    endtask
    task automatic fw(input logic [23:0] a, input logic [15:0] d);
        wr(flash_host_pkg::REG_ADDR, {8'h0, a});
        wr(flash_host_pkg::REG_WDATA, {16'h0, d});
        go(3'h1);
    endtask
    always @(posedge clk_sys)
        rd_d <= reg_rd;
    always @(negedge clk_sys) begin
        if (rd_d && q.size() > 0) begin
            check(q[0].nm, reg_rdata & q[0].m, q[0].e);
            void'(q.pop_front());
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        st(1'b0);
        rd(4'hF, "unmapped", 32'hFFFFFFFF, 32'h0);
        op(3'h7, 3'h0, 1'b1);
        fw(24'h555, 16'h00AA);
        fw(24'h2AA, 16'h0055);
        op(3'h2, 3'h0, 1'b0);
        rda(24'h555, 16'h5F0F);
        repeat (6) begin
            lfsr = nx(lfsr);
            rda(lfsr[23:0] & 24'h3FFFFF, lfsr[15:0] ^ 16'h5A5A);
        end
        st(1'b0);
        op(3'h2, 3'h0, 1'b0);
        $display("test idle and array reads done");
        op(3'h3, 3'h2, 1'b0);
        foreach (ia[i]) rda(ia[i], iv[i]);
        op(3'h4, 3'h3, 1'b0);
        foreach (qa[i]) rda({16'h0, qa[i]}, qv[i]);
        op(3'h2, 3'h0, 1'b0);
        wr(flash_host_pkg::REG_CTRL, 32'h1);
        byte_mode <= 1'b1;
        op(3'h4, 3'h3, 1'b0);
        rda(24'h27, 16'h0017);
        op(3'h2, 3'h0, 1'b0);
        wr(flash_host_pkg::REG_CTRL, 32'h0);
        byte_mode <= 1'b0;
        $display("test identifier and query done");
        wr(flash_host_pkg::REG_CTRL, 32'h2);
        op(3'h3, 3'h2, 1'b0);
        op(3'h2, 3'h1, 1'b0);
        op(3'h5, 3'h1, 1'b1);
        wr(flash_host_pkg::REG_CTRL, 32'h0);
        op(3'h2, 3'h0, 1'b0);
        op(3'h5, 3'h4, 1'b0);
        rda(24'h0, SER);
        rda(24'h7, SER + 16'h7);
        op(3'h4, 3'h4, 1'b1);
        op(3'h6, 3'h0, 1'b0);
        rda(24'h7, 16'h5A5D);
        $display("test suspend and secure done");
        summarize();
    end
endmodule
bind flash_cmd_host flash_host_properties chk (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i));
`default_nettype wire
